/* common/cbc_pkg.sv */
`default_nettype none
package cbc_pkg;
    // ----------------------------------------------------------------
    // Register indices and byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0]  IDX_SERIAL_RATE = 8'h3B;
    localparam logic [7:0]  IDX_SLOW_TRIM   = 8'h3C;
    localparam logic [7:0]  IDX_LOOP_CTRL   = 8'h3D;
    localparam logic [7:0]  IDX_LOOP_OUTDIV = 8'h3E;
    localparam logic [7:0]  IDX_STATUS      = 8'h30;
    localparam logic [9:0]  ADDR_SERIAL_RATE = {IDX_SERIAL_RATE, 2'b00};
    localparam logic [9:0]  ADDR_SLOW_TRIM   = {IDX_SLOW_TRIM, 2'b00};
    localparam logic [9:0]  ADDR_LOOP_CTRL   = {IDX_LOOP_CTRL, 2'b00};
    localparam logic [9:0]  ADDR_LOOP_OUTDIV = {IDX_LOOP_OUTDIV, 2'b00};
    localparam logic [9:0]  ADDR_STATUS      = {IDX_STATUS, 2'b00};
    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0]  RST_SERIAL_RATE = 8'h7A;
    localparam logic [7:0]  RST_SLOW_TRIM   = 8'h80;
    localparam logic [7:0]  RST_LOOP_CTRL   = 8'h04;
    localparam logic [7:0]  RST_LOOP_OUTDIV = 8'h08;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int          EXP_LSB     = 5;
    localparam int          EXP_MSB     = 7;
    localparam int          MANT_LSB    = 0;
    localparam int          MANT_MSB    = 4;
    localparam int          SEL_LSB     = 4;
    localparam int          SEL_MSB     = 7;
    localparam int          OUT_EN_BIT  = 3;
    localparam int          PWR_DN_BIT  = 2;
    localparam int          FB_LSB      = 0;
    localparam int          FB_MSB      = 1;
    localparam int          ST_LOOP_OK  = 0;
    localparam int          ST_TOO_FAST = 1;
    localparam int          ST_PIN_IN   = 2;
    localparam int          ST_PIN_OUT  = 3;
    // ----------------------------------------------------------------
    // Divider arithmetic
    // ----------------------------------------------------------------
    localparam logic [12:0] MANT_OFS_ZERO  = 13'h0001;
    localparam logic [12:0] MANT_OFS_SCALE = 13'h0021;
    localparam logic [12:0] MIN_RATE_DIV   = 13'h0016;
    localparam logic [3:0]  FRAME_BITS     = 4'hA;
    localparam logic [4:0]  FB_FACTOR_0    = 5'h17;
    localparam logic [4:0]  FB_FACTOR_1    = 5'h1B;
    localparam logic [4:0]  FB_FACTOR_2    = 5'h1C;
    localparam logic [7:0]  OUTDIV_MIN     = 8'h08;
    // ----------------------------------------------------------------
    // Clock pin sources
    // ----------------------------------------------------------------
    localparam logic [3:0]  SRC_GPIO    = 4'h0;
    localparam logic [3:0]  SRC_LOOP    = 4'h1;
    localparam logic [3:0]  SRC_LOW     = 4'h2;
    localparam logic [3:0]  SRC_HIGH    = 4'h3;
    localparam logic [3:0]  SRC_XTAL_1  = 4'h4;
    localparam logic [3:0]  SRC_XTAL_2  = 4'h5;
    localparam logic [3:0]  SRC_XTAL_4  = 4'h6;
    localparam logic [3:0]  SRC_XTAL_8  = 4'h7;
    localparam logic [3:0]  SRC_TMR_0   = 4'h8;
    localparam logic [3:0]  SRC_TMR_1   = 4'h9;
    localparam logic [3:0]  SRC_TMR_2   = 4'hA;
    localparam logic [3:0]  SRC_TMR_3   = 4'hB;
endpackage
`default_nettype wire

/* rtl/cbc_rate_gen.sv */
`default_nettype none
module cbc_rate_gen
    import cbc_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Setting and reference
    input  wire logic [7:0]  rate_cfg,
    input  wire logic        ref_tick,
    // Ticks out
    output logic             bit_tick,
    output logic             char_tick,
    output logic [12:0]      rate_div
);
    // ----------------------------------------------------------------
    // Divisor from exponent and mantissa
    // ----------------------------------------------------------------
    logic [2:0]  rate_exponent;
    logic [4:0]  rate_mantissa;
    logic [12:0] base_div;
    logic [12:0] cnt_q;
    logic [3:0]  bit_cnt_q;

    assign rate_exponent = rate_cfg[EXP_MSB:EXP_LSB];
    assign rate_mantissa = rate_cfg[MANT_MSB:MANT_LSB];

    always_comb begin
        if (rate_exponent == 3'h0) begin
            base_div = {8'h00, rate_mantissa} + MANT_OFS_ZERO;
            rate_div = base_div;
        end else begin
            base_div = {8'h00, rate_mantissa} + MANT_OFS_SCALE;
            rate_div = 13'(base_div << (rate_exponent - 3'h1));
        end
    end

    // ----------------------------------------------------------------
    // Bit period counter in reference ticks
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 13'h0000;
        end else if (ref_tick) begin
            if (cnt_q + 13'h0001 >= rate_div) begin
                cnt_q <= 13'h0000;
            end else begin
                cnt_q <= cnt_q + 13'h0001;
            end
        end
    end

    assign bit_tick = ref_tick && (cnt_q + 13'h0001 >= rate_div);

    // ----------------------------------------------------------------
    // Character framing: start, eight data, stop, no parity
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bit_cnt_q <= 4'h0;
        end else if (bit_tick) begin
            if (bit_cnt_q == FRAME_BITS - 4'h1) begin
                bit_cnt_q <= 4'h0;
            end else begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end
        end
    end

    assign char_tick = bit_tick && (bit_cnt_q == FRAME_BITS - 4'h1);
endmodule
`default_nettype wire

/* rtl/cbc_top.sv */
`default_nettype none
module cbc_top
    import cbc_pkg::*;
#(
    parameter int TIMERS = 4
)
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Reference and loop clocks from pins
    input  wire logic        xtal_clk_in,
    input  wire logic        loop_clk_in,
    // Timer overflow pulses from on-chip timers
    input  wire logic [TIMERS-1:0] timer_overflow,
    // Clock output pin
    input  wire logic        clock_output_pin_in,
    output logic             clock_output_pin_out,
    output logic             clock_output_pin_oe_n,
    // Serial rate ticks
    output logic             serial_bit_tick,
    output logic             serial_char_tick,
    output logic             serial_parity_enable,
    // Analog controls
    output logic [7:0]       low_freq_oscillator_code,
    output logic             loop_power_down,
    output logic [4:0]       loop_feedback_factor,
    output logic [7:0]       loop_output_divider
);
    // Elaboration check: the source decoder serves exactly four timers.
    if (TIMERS != 4) begin : g_bad_timers
        $error("cbc_top serves exactly four timers");
    end


    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] xtal_sync_q;
    logic [1:0] loop_sync_q;
    logic [1:0] pin_sync_q;
    logic       xtal_level;
    logic       xtal_prev_q;
    logic       ref_tick;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xtal_sync_q <= 2'h0;
            loop_sync_q <= 2'h0;
            pin_sync_q  <= 2'h0;
            xtal_prev_q <= 1'b0;
        end else begin
            xtal_sync_q <= {xtal_sync_q[0], xtal_clk_in};
            loop_sync_q <= {loop_sync_q[0], loop_clk_in};
            pin_sync_q  <= {pin_sync_q[0], clock_output_pin_in};
            xtal_prev_q <= xtal_sync_q[1];
        end
    end

    assign xtal_level = xtal_sync_q[1];
    assign ref_tick   = xtal_level && !xtal_prev_q;

    // ----------------------------------------------------------------
    // AHB-Lite address phase capture
    // ----------------------------------------------------------------
    logic       wr_pend_q;
    logic [9:0] wr_addr_q;
    logic       acc_valid;
    logic [9:0] acc_addr;

    assign acc_valid = hsel && htrans[1] && hready && (hsize == 3'h2);
    assign acc_addr  = haddr[9:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 10'h000;
        end else begin
            wr_pend_q <= acc_valid && hwrite && (haddr[31:10] == 22'h000000);
            wr_addr_q <= acc_addr;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] serial_rate_config_q;
    logic [7:0] slow_osc_trim_q;
    logic [7:0] loop_ctrl_q;
    logic [7:0] loop_outdiv_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serial_rate_config_q <= RST_SERIAL_RATE;
        end else if (wr_pend_q && wr_addr_q == ADDR_SERIAL_RATE) begin
            serial_rate_config_q <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slow_osc_trim_q <= RST_SLOW_TRIM;
        end else if (wr_pend_q && wr_addr_q == ADDR_SLOW_TRIM) begin
            slow_osc_trim_q <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            loop_ctrl_q <= RST_LOOP_CTRL;
        end else if (wr_pend_q && wr_addr_q == ADDR_LOOP_CTRL) begin
            loop_ctrl_q <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            loop_outdiv_q <= RST_LOOP_OUTDIV;
        end else if (wr_pend_q && wr_addr_q == ADDR_LOOP_OUTDIV) begin
            loop_outdiv_q <= hwdata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Field views
    // ----------------------------------------------------------------
    logic [3:0] clock_pin_source_select;
    logic       clock_pin_output_enable;
    logic [1:0] loop_feedback_divider;

    assign clock_pin_source_select = loop_ctrl_q[SEL_MSB:SEL_LSB];
    assign clock_pin_output_enable = loop_ctrl_q[OUT_EN_BIT];
    assign loop_feedback_divider   = loop_ctrl_q[FB_MSB:FB_LSB];

    // ----------------------------------------------------------------
    // Serial bit-rate generator
    // ----------------------------------------------------------------
    logic [12:0] rate_div;
    logic        rate_too_fast;

    cbc_rate_gen u_rate (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .rate_cfg  (serial_rate_config_q),
        .ref_tick  (ref_tick),
        .bit_tick  (serial_bit_tick),
        .char_tick (serial_char_tick),
        .rate_div  (rate_div)
    );

    assign serial_parity_enable = 1'b0;
    assign rate_too_fast = rate_div < MIN_RATE_DIV;

    // ----------------------------------------------------------------
    // Slow oscillator and loop controls
    // ----------------------------------------------------------------
    logic [4:0] fb_factor_d;
    logic [7:0] outdiv_d;

    always_comb begin
        case (loop_feedback_divider)
            2'h0: fb_factor_d = FB_FACTOR_0;
            2'h1: fb_factor_d = FB_FACTOR_1;
            2'h2: fb_factor_d = FB_FACTOR_2;
            default: fb_factor_d = FB_FACTOR_0;
        endcase
    end

    // Reserved settings below 8 are raised to 8 so the divider stays defined.
    assign outdiv_d = (loop_outdiv_q < OUTDIV_MIN) ? OUTDIV_MIN : loop_outdiv_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_freq_oscillator_code <= 8'hFF;
            loop_power_down          <= 1'b1;
            loop_feedback_factor     <= FB_FACTOR_0;
            loop_output_divider      <= OUTDIV_MIN;
        end else begin
            low_freq_oscillator_code <= ~slow_osc_trim_q;
            loop_power_down          <= loop_ctrl_q[PWR_DN_BIT];
            loop_feedback_factor     <= fb_factor_d;
            loop_output_divider      <= outdiv_d;
        end
    end

    // ----------------------------------------------------------------
    // Crystal dividers
    // ----------------------------------------------------------------
    logic [2:0] xtal_div_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xtal_div_q <= 3'h0;
        end else if (ref_tick) begin
            xtal_div_q <= xtal_div_q + 3'h1;
        end
    end

    // ----------------------------------------------------------------
    // Timer overflow toggles
    // ----------------------------------------------------------------
    logic [TIMERS-1:0] tmr_tog_q;

    genvar gi;
    generate
        for (gi = 0; gi < TIMERS; gi++) begin : g_tmr
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    tmr_tog_q[gi] <= 1'b0;
                end else if (timer_overflow[gi]) begin
                    tmr_tog_q[gi] <= ~tmr_tog_q[gi];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Clock pin source selection
    // ----------------------------------------------------------------
    logic loop_ok;
    logic src_d;
    logic pin_out_d;
    logic pin_oe_n_d;

    assign loop_ok = !loop_ctrl_q[PWR_DN_BIT];

    always_comb begin
        case (clock_pin_source_select)
            SRC_GPIO:   src_d = 1'b0;
            SRC_LOOP:   src_d = loop_ok && loop_sync_q[1];
            SRC_LOW:    src_d = 1'b0;
            SRC_HIGH:   src_d = 1'b1;
            SRC_XTAL_1: src_d = xtal_level;
            SRC_XTAL_2: src_d = xtal_div_q[0];
            SRC_XTAL_4: src_d = xtal_div_q[1];
            SRC_XTAL_8: src_d = xtal_div_q[2];
            SRC_TMR_0:  src_d = tmr_tog_q[0];
            SRC_TMR_1:  src_d = tmr_tog_q[1];
            SRC_TMR_2:  src_d = tmr_tog_q[2];
            SRC_TMR_3:  src_d = tmr_tog_q[3];
            default:    src_d = 1'b0;
        endcase
    end

    always_comb begin
        pin_oe_n_d = (clock_pin_source_select == SRC_GPIO);
        pin_out_d  = clock_pin_output_enable && src_d;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clock_output_pin_out  <= 1'b0;
            clock_output_pin_oe_n <= 1'b1;
        end else begin
            clock_output_pin_out  <= pin_out_d;
            clock_output_pin_oe_n <= pin_oe_n_d;
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    logic [7:0]  status_v;
    logic [31:0] rdata_d;

    always_comb begin
        status_v              = 8'h00;
        status_v[ST_LOOP_OK]  = loop_ok;
        status_v[ST_TOO_FAST] = rate_too_fast;
        status_v[ST_PIN_IN]   = pin_sync_q[1];
        status_v[ST_PIN_OUT]  = clock_output_pin_out;
    end

    always_comb begin
        rdata_d = 32'h00000000;
        if (acc_valid && !hwrite && haddr[31:10] == 22'h000000) begin
            case (acc_addr)
                ADDR_SERIAL_RATE: rdata_d = {24'h000000, serial_rate_config_q};
                ADDR_SLOW_TRIM:   rdata_d = {24'h000000, slow_osc_trim_q};
                ADDR_LOOP_CTRL:   rdata_d = {24'h000000, loop_ctrl_q};
                ADDR_LOOP_OUTDIV: rdata_d = {24'h000000, loop_outdiv_q};
                ADDR_STATUS:      rdata_d = {24'h000000, status_v};
                default:          rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (hready) begin
            hrdata <= rdata_d;
        end
    end
endmodule
`default_nettype wire

/* verif/cbc_top_sva.sv */
`default_nettype none
module cbc_top_sva
    import cbc_pkg::*;
#(
    parameter int TIMERS = 4
)
(
    // Clock and bus
    input wire logic              hclk,
    input wire logic              hresetn,
    input wire logic              hsel,
    input wire logic [31:0]       haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic [2:0]        hsize,
    input wire logic [31:0]       hwdata,
    input wire logic              hready,
    // Block pins
    input wire logic [TIMERS-1:0] timer_overflow,
    input wire logic              clock_output_pin_out,
    input wire logic              clock_output_pin_oe_n,
    input wire logic              serial_bit_tick,
    input wire logic              serial_char_tick,
    input wire logic [7:0]        low_freq_oscillator_code,
    input wire logic              loop_power_down,
    input wire logic [4:0]        loop_feedback_factor,
    input wire logic [7:0]        loop_output_divider
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       wr_q;
    logic [3:0] bits_q;
    logic [9:0] wa_q;
    logic [7:0] ctl_q;
    logic [7:0] wd;
    logic       ctl_wr;
    assign wd = hwdata[7:0];
    assign ctl_wr = wr_q && hready && wa_q == ADDR_LOOP_CTRL;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            wa_q <= 10'h000;
        end else if (hready) begin
            wr_q <= hsel && htrans[1] && hwrite && hsize == 3'h2 && haddr[31:10] == 22'h0;
            wa_q <= haddr[9:0];
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_q <= RST_LOOP_CTRL;
        end else if (ctl_wr) begin
            ctl_q <= wd;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bits_q <= 4'h0;
        end else if (serial_bit_tick) begin
            bits_q <= serial_char_tick ? 4'h0 : bits_q + 4'h1;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_osc;
        wr_q && wa_q == ADDR_SLOW_TRIM |-> ##2 low_freq_oscillator_code == ~$past(wd, 2);
    endproperty
    a_osc: assert property (p_osc) else $error("osc code wrong");
    property p_div;
        wr_q && wa_q == ADDR_LOOP_OUTDIV |->
            ##2 loop_output_divider == ($past(wd, 2) < 8'h08 ? 8'h08 : $past(wd, 2));
    endproperty
    a_div: assert property (p_div) else $error("out divider wrong");
    property p_fb;
        ctl_wr |-> ##2 loop_feedback_factor == ($past(wd[1:0], 2) == 2'b01 ? 5'h1B :
            $past(wd[1:0], 2) == 2'b10 ? 5'h1C : 5'h17);
    endproperty
    a_fb: assert property (p_fb) else $error("feedback factor wrong");
    property p_pd;
        ctl_wr |-> ##2 loop_power_down == $past(wd[2], 2);
    endproperty
    a_pd: assert property (p_pd) else $error("power down wrong");
    property p_oe;
        ctl_wr |-> ##2 clock_output_pin_oe_n == ($past(wd[7:4], 2) == 4'h0);
    endproperty
    a_oe: assert property (p_oe) else $error("pin enable wrong");
    property p_low;
        ctl_wr && (!wd[3] || wd[7:4] == 4'h2 || wd[7:4] >= 4'hC) |->
            ##2 !clock_output_pin_out [*2];
    endproperty
    a_low: assert property (p_low) else $error("pin not low");
    property p_tmr;
        ctl_q[7:6] == 2'b10 && ctl_q[3] && timer_overflow[ctl_q[5:4]] |->
            ##2 clock_output_pin_out != $past(clock_output_pin_out, 2);
    endproperty
    a_tmr: assert property (p_tmr) else $error("pin not toggled");
    property p_char;
        serial_bit_tick || serial_char_tick |->
            serial_bit_tick && (serial_char_tick == (bits_q == 4'h9));
    endproperty
    a_char: assert property (p_char) else $error("char tick off bit tick");
endmodule
bind cbc_top cbc_top_sva #(.TIMERS(TIMERS)) i_sva (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .timer_overflow, .clock_output_pin_out, .clock_output_pin_oe_n, .serial_bit_tick,
    .serial_char_tick, .low_freq_oscillator_code, .loop_power_down,
    .loop_feedback_factor, .loop_output_divider
);
`default_nettype wire

/* verif/tb_cbc_top.sv */
`default_nettype none
module tb_cbc_top
    import cbc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, p, pin_ext;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [2:0]  xt_cnt = 3'h0;
    logic        xtal_clk_in, loop_clk_in, clock_output_pin_in, clock_output_pin_out;
    logic        clock_output_pin_oe_n, serial_bit_tick, serial_char_tick;
    logic        serial_parity_enable, loop_power_down;
    logic [3:0]  timer_overflow;
    logic [7:0]  low_freq_oscillator_code, loop_output_divider;
    logic [4:0]  loop_feedback_factor;
    logic [7:0]  tv [5] = '{8'h00, 8'h07, 8'h08, 8'h3C, 8'hFE};
    logic [4:0]  fbv [4] = '{5'h17, 5'h1B, 5'h1C, 5'h17};
    logic [7:0]  cv [6] = '{8'h1C, 8'h18, 8'h4C, 8'h5C, 8'h6C, 8'h7C};
    int          ev [6] = '{0, 16, 32, 16, 8, 4};
    logic [7:0]  sv [6] = '{8'h2C, 8'h3C, 8'hCC, 8'hFC, 8'h34, 8'h0C};
    logic [7:0]  rv [7] = '{8'h7A, 8'hE0, 8'h5A, 8'h21, 8'h1C, 8'h15, 8'h16};
    int          n_errors = 0;
    int          num_checks = 0;
    assign hready = hreadyout;
    assign xtal_clk_in = xt_cnt[1];
    assign loop_clk_in = xt_cnt[2];
    assign clock_output_pin_in = clock_output_pin_oe_n ? pin_ext : clock_output_pin_out;
    cbc_top i_dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hreadyout, .hresp, .hrdata, .xtal_clk_in, .loop_clk_in, .timer_overflow,
        .clock_output_pin_in, .clock_output_pin_out, .clock_output_pin_oe_n,
        .serial_bit_tick, .serial_char_tick, .serial_parity_enable,
        .low_freq_oscillator_code, .loop_power_down, .loop_feedback_factor,
        .loop_output_divider
    );
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    always @(posedge hclk) xt_cnt <= xt_cnt + 3'h1;
    task automatic stop_test();
        $display("Checks %0d, errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic chkb(input string s, input logic e, input logic g);
        chk(s, {31'h0, e}, {31'h0, g});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {22'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'hA5A5A5, d};
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task automatic rdc(input string s, input logic [9:0] a, input logic [31:0] e);
        bus(1'b0, a, 8'h00);
        chk(s, e, r);
        chkb("resp", 1'b0, hresp);
    endtask
    task automatic edges(output int n);
        logic q;
        n = 0;
        q = clock_output_pin_out;
        repeat (128) begin
            @(posedge hclk);
            n += (clock_output_pin_out === 1'b1 && q !== 1'b1);
            q = clock_output_pin_out;
        end
    endtask
    task automatic gap(output int c);
        c = 0;
        do begin
            @(posedge hclk);
            c++;
        end while (serial_bit_tick !== 1'b1);
    endtask
    task automatic pulse(input int t);
        @(posedge hclk);
        timer_overflow <= 4'(1 << t);
        @(posedge hclk);
        timer_overflow <= 4'h0;
        cyc(4);
    endtask
    initial begin
        repeat (60000) @(posedge hclk);
        n_errors++;
        stop_test();
    end
    initial begin
        int n, d;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = 32'h0;
        timer_overflow = 4'h0;
        pin_ext = 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        rdc("rate", ADDR_SERIAL_RATE, 32'h7A);
        rdc("unmapped", 10'h0FC, 32'h0);
        chkb("pd", 1'b1, loop_power_down);
        foreach (tv[i]) begin
            bus(1'b1, ADDR_SLOW_TRIM, tv[i]);
            bus(1'b1, ADDR_LOOP_OUTDIV, tv[i]);
            cyc(2);
            chk("osc", {24'h0, ~tv[i]}, low_freq_oscillator_code);
            chk("outdiv", tv[i] < 8'h08 ? 8'h08 : tv[i], loop_output_divider);
            rdc("outdiv reg", ADDR_LOOP_OUTDIV, tv[i]);
        end
        for (int f = 0; f < 4; f++) begin
            bus(1'b1, ADDR_LOOP_CTRL, 8'(f));
            cyc(2);
            chk("fb", fbv[f], loop_feedback_factor);
            rdc("ctrl reg", ADDR_LOOP_CTRL, f);
        end
        rdc("status", ADDR_STATUS, 32'h1);
        foreach (cv[i]) begin
            bus(1'b1, ADDR_LOOP_CTRL, cv[i]);
            cyc(8);
            edges(n);
            chkb("edges", 1'b1, n >= ev[i] - 1 && n <= ev[i] + 1);
        end
        foreach (sv[i]) begin
            bus(1'b1, ADDR_LOOP_CTRL, sv[i]);
            cyc(4);
            chkb("oe_n", sv[i][7:4] == 4'h0, clock_output_pin_oe_n);
            chkb("pin", sv[i] == 8'h3C, clock_output_pin_out);
        end
        pin_ext <= 1'b1;
        cyc(6);
        bus(1'b0, ADDR_STATUS, 8'h00);
        chkb("pin in", 1'b1, r[ST_PIN_IN]);
        for (int t = 0; t < 4; t++) begin
            bus(1'b1, ADDR_LOOP_CTRL, {4'h8 + 4'(t), 4'hC});
            cyc(4);
            p = clock_output_pin_out;
            pulse(t);
            chkb("tmr", ~p, clock_output_pin_out);
            pulse((t + 1) % 4);
            chkb("tmr other", ~p, clock_output_pin_out);
        end
        foreach (rv[i]) begin
            bus(1'b1, ADDR_SERIAL_RATE, rv[i]);
            d = rv[i][7:5] == 3'h0 ? int'(rv[i][4:0]) + 1 :
                (int'(rv[i][4:0]) + 33) << (int'(rv[i][7:5]) - 1);
            repeat (3) gap(n);
            chk("bit period", 4 * d, n);
            bus(1'b0, ADDR_STATUS, 8'h00);
            chkb("too fast", d < 22, r[ST_TOO_FAST]);
        end
        do @(posedge hclk); while (serial_char_tick !== 1'b1);
        n = 0;
        do begin
            @(posedge hclk);
            n += (serial_bit_tick === 1'b1);
        end while (serial_char_tick !== 1'b1);
        chk("bits per char", 10, n);
        chkb("parity", 1'b0, serial_parity_enable);
        stop_test();
    end
endmodule
`default_nettype wire
